// ==== dv/lpe_adc_model.sv ====
`timescale 1ns/1ps
module lpe_adc_model (
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // level to convert
  input  wire [7:0] level_i,
  output reg  [7:0] adc_result_o
);
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) adc_result_o <= 8'h00;
    else adc_result_o <= level_i;
  end
endmodule

// ==== dv/lpe_ramp_engine_tb_top.sv ====
`timescale 1ns/1ps
`include "lpe_defs.vh"
module lpe_ramp_engine_tb_top;
  localparam integer BT = 16 * 305;
  reg         clk_i, rst_i, avs_read_i, avs_write_i;
  reg  [8:0]  avs_address_i;
  reg  [31:0] avs_writedata_i, q;
  reg  [7:0]  lvl;
  wire [31:0] avs_readdata_o;
  wire        avs_waitrequest_o, engine_busy_o;
  wire [7:0]  adc, led0, led1, led2;
  integer     err_count, cmp_count, d, i;
  lpe_adc_model adc_m (.clk_i(clk_i), .rst_i(rst_i), .level_i(lvl), .adc_result_o(adc));
  lpe_ramp_engine dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .adc_result_i(adc),
    .led_current0_o(led0), .led_current1_o(led1), .led_current2_o(led2), .engine_busy_o(engine_busy_o));
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task conclude;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  // hold the request until waitrequest is sampled low
  task bus(input wr, input [6:0] idx, input [15:0] wd);
    integer n;
    begin
      avs_address_i <= {idx, 2'b00};
      avs_writedata_i <= {16'h0000, wd};
      avs_write_i <= wr;
      avs_read_i <= !wr;
      n = 0;
      @(posedge clk_i);
      while (avs_waitrequest_o !== 1'b0 && n < 20) begin
        @(posedge clk_i);
        n = n + 1;
      end
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      if (n == 20) chk(32'h0, 32'h1);
      @(posedge clk_i);
    end
  endtask
  task wait_idle;
    integer n;
    begin
      n = 0;
      while (engine_busy_o !== 1'b1 && n < 10) begin
        @(posedge clk_i);
        n = n + 1;
      end
      d = 0;
      while (engine_busy_o === 1'b1 && d < 200000) begin
        @(posedge clk_i);
        d = d + 1;
      end
      @(posedge clk_i);
    end
  endtask
  // mid changes the converter level once the ramp has begun
  task ramp_chk(input [15:0] ins, input [7:0] mid, input [7:0] exp, input integer nb);
    begin
      bus(1'b1, `LPE_IDX_INSTR, ins);
      lvl <= mid;
      wait_idle;
      chk(32'(led0), 32'(exp));
      chk(32'(d >= nb * BT - 5 && d <= nb * BT + 320), 32'h1);
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    err_count = err_count + 1;
    conclude;
  end
  initial begin
    err_count = 0;
    cmp_count = 0;
    rst_i = 1'b1;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 9'h000;
    avs_writedata_i = 32'h0;
    lvl = 8'h00;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, `LPE_IDX_VAR_D, 16'h0);
    chk(q, 32'h0);
    bus(1'b1, `LPE_IDX_VAR_D, 16'h005a);
    bus(1'b0, `LPE_IDX_VAR_D, 16'h0);
    chk(q, 32'h5a);
    bus(1'b1, `LPE_IDX_VAR_A, 16'h0077);
    bus(1'b0, `LPE_IDX_VAR_A, 16'h0);
    chk(q, 32'h0);
    bus(1'b1, 7'h7f, 16'h00ff);
    bus(1'b0, 7'h7f, 16'h0);
    chk(q, 32'h0);
    bus(1'b1, `LPE_IDX_PWM0, 16'h0010);
    ramp_chk(16'h0203, 8'h00, 8'h13, 3);
    bus(1'b1, `LPE_IDX_PWM0, 16'h0001);
    ramp_chk(16'h0303, 8'h00, 8'h00, 3);
    ramp_chk(16'h0200, 8'h00, 8'h00, 1);
    ramp_chk(16'h0401, 8'h41, 8'h01, 2);
    bus(1'b1, `LPE_IDX_CFG, 16'h0001);
    for (i = 0; i < 3; i = i + 1) begin
      bus(1'b1, `LPE_IDX_INSTR, {4'h9, 2'h0, i[1:0], (i == 0) ? 8'h02 : 8'h01});
      wait_idle;
      bus(1'b0, `LPE_IDX_VAR_A, 16'h0);
      chk(q, (i == 1) ? 32'h3 : 32'h2);
    end
    // step from the converter (low bits 1), count from A; a late level change must not count
    bus(1'b1, `LPE_IDX_PWM0, 16'h0020);
    ramp_chk(16'h840c, 8'h5f, 8'h22, 2);
    // register-to-register forms, the difference wraps below zero
    bus(1'b1, `LPE_IDX_INSTR, 16'h9303);
    wait_idle;
    bus(1'b0, `LPE_IDX_VAR_A, 16'h0);
    chk(q, 32'h61);
    bus(1'b1, `LPE_IDX_INSTR, 16'h931c);
    wait_idle;
    bus(1'b0, `LPE_IDX_VAR_A, 16'h0);
    chk(q, 32'hfe);
    bus(1'b1, `LPE_IDX_CTRL0, 16'h0020);
    bus(1'b1, `LPE_IDX_PWM0, 16'h0080);
    bus(1'b1, `LPE_IDX_PWM1, 16'h0080);
    bus(1'b1, `LPE_IDX_PWM2, 16'h0030);
    repeat (2) @(posedge clk_i);
    chk(32'(led0), 32'h40);
    chk(32'(led1), 32'h80);
    chk(32'(led2), 32'h30);
    bus(1'b1, `LPE_IDX_INSTR, 16'h4201);
    repeat (2 * BT) @(posedge clk_i);
    chk(32'(engine_busy_o), 32'h1);
    chk(32'(led0), 32'h40);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(32'(engine_busy_o), 32'h0);
    chk(32'(led0), 32'h0);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, `LPE_IDX_VAR_A, 16'h0);
    chk(q, 32'h0);
    conclude;
  end
endmodule

// ==== dv/lpe_ramp_sva.sv ====
`timescale 1ns/1ps
`include "lpe_defs.vh"
module lpe_ramp_sva (
  // clock and reset
  input wire        clk_i,
  input wire        rst_i,
  // bus
  input wire [8:0]  avs_address_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0]  avs_byteenable_i,
  input wire [31:0] avs_readdata_o,
  input wire        avs_waitrequest_o,
  // drivers
  input wire [7:0]  adc_result_i,
  input wire [7:0]  led_current0_o,
  input wire [7:0]  led_current1_o,
  input wire [7:0]  led_current2_o,
  input wire        engine_busy_o
);
  wire req;
  reg  ramp_cmd;
  assign req = avs_read_i | avs_write_i;
  // arithmetic may end on the next master tick, only ramps run a full base tick
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ramp_cmd <= 1'b0;
    end else if (avs_write_i && !avs_waitrequest_o && !engine_busy_o && avs_address_i[8:2] == `LPE_IDX_INSTR) begin
      ramp_cmd <= !avs_writedata_i[15] || (avs_writedata_i[15:6] == `LPE_OP_RAMP_VAR);
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_wait_first; $rose(req) |-> avs_waitrequest_o; endproperty
  property p_ack_one; (req && avs_waitrequest_o) ##1 req |-> !avs_waitrequest_o; endproperty
  property p_idle_nowait; !req |-> !avs_waitrequest_o; endproperty
  property p_rd_hi; avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:16] == 16'h0000; endproperty
  property p_busy_cause;
    $rose(engine_busy_o) |-> $past(avs_write_i) && !$past(avs_waitrequest_o)
      && ($past(avs_address_i) & 9'h1fc) == {`LPE_IDX_INSTR, 2'b00};
  endproperty
  property p_busy_min; $rose(engine_busy_o) && ramp_cmd |=> engine_busy_o [*8]; endproperty
  // steps are thousands of clocks apart, so a step is never followed closely by another
  property p_step_slow; $changed(led_current0_o) && engine_busy_o |=> $stable(led_current0_o) [*8]; endproperty
  property p_sat;
    engine_busy_o && $past(engine_busy_o) |-> ($past(led_current0_o) == 8'hff -> led_current0_o != 8'h00)
      && ($past(led_current0_o) == 8'h00 -> led_current0_o != 8'hff);
  endproperty
  property p_idle_hold;
    !engine_busy_o && !$past(engine_busy_o) && !$past(avs_write_i) && !$past(avs_write_i, 2)
      |-> $stable(led_current0_o);
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait state on first cycle");
  a_ack_one: assert property (p_ack_one) else $error("more than one wait state");
  a_idle_nowait: assert property (p_idle_nowait) else $error("waitrequest without request");
  a_rd_hi: assert property (p_rd_hi) else $error("unused read bits not zero");
  a_busy_cause: assert property (p_busy_cause) else $error("engine started without instr write");
  a_busy_min: assert property (p_busy_min) else $error("instruction ended too soon");
  a_step_slow: assert property (p_step_slow) else $error("brightness stepped too fast");
  a_sat: assert property (p_sat) else $error("brightness wrapped");
  a_idle_hold: assert property (p_idle_hold) else $error("brightness moved while idle");
  c_ramp: cover property ($rose(engine_busy_o));
  c_sat: cover property (engine_busy_o && led_current0_o == 8'h00);
  c_read: cover property (avs_read_i && !avs_waitrequest_o);
endmodule
bind lpe_ramp_engine lpe_ramp_sva u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .adc_result_i(adc_result_i),
  .led_current0_o(led_current0_o), .led_current1_o(led_current1_o), .led_current2_o(led_current2_o),
  .engine_busy_o(engine_busy_o));

// ==== logic/lpe_defs.vh ====
`ifndef LPE_DEFS_VH
`define LPE_DEFS_VH

// timing
`define LPE_CLK_HZ          10000000
`define LPE_MCLK_HZ         32768
`define LPE_MCLK_DIV        (`LPE_CLK_HZ / `LPE_MCLK_HZ)
`define LPE_PRE_FAST_DIV    16
`define LPE_PRE_SLOW_DIV    512

// register indices, byte address is four times the index
`define LPE_IDX_CTRL0       7'h06
`define LPE_IDX_CTRL1       7'h07
`define LPE_IDX_CTRL2       7'h08
`define LPE_IDX_PWM0        7'h16
`define LPE_IDX_PWM1        7'h17
`define LPE_IDX_PWM2        7'h18
`define LPE_IDX_VAR_D       7'h3c
`define LPE_IDX_ADC         7'h42
`define LPE_IDX_INSTR       7'h50
`define LPE_IDX_STATUS      7'h51
`define LPE_IDX_VAR_A       7'h52
`define LPE_IDX_CFG         7'h53

// fields
`define LPE_CTRL_LOG_EN_BIT 5
`define LPE_CFG_D_ADC_BIT   0
`define LPE_CFG_CH_LSB      1
`define LPE_RST_8           8'h00
`define LPE_RST_16          16'h0000

// instruction encodings
`define LPE_OP_RAMP_VAR     10'h210
`define LPE_OP_ARITH        4'h9
`define LPE_AR_LD           2'h0
`define LPE_AR_ADD          2'h1
`define LPE_AR_SUB          2'h2
`define LPE_AR_VAR          2'h3
`define LPE_AR_VADD         4'h0
`define LPE_AR_VSUB         4'h1

`endif

// ==== logic/lpe_divider.v ====
`timescale 1ns/1ps
module lpe_divider #(
  parameter DIV   = 16,
  parameter WIDTH = 10
) (
  // clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // control
  input  wire clr_i,
  input  wire en_i,
  // tick
  output wire tick_o
);
  reg [WIDTH-1:0] cnt_reg;
  localparam integer     LAST_I = DIV - 1;
  localparam [WIDTH-1:0] LAST   = LAST_I[WIDTH-1:0];

  assign tick_o = en_i & (cnt_reg == LAST);

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= {WIDTH{1'b0}};
    end else if (clr_i) begin
      cnt_reg <= {WIDTH{1'b0}};
    end else if (en_i) begin
      if (cnt_reg == LAST) begin
        cnt_reg <= {WIDTH{1'b0}};
      end else begin
        cnt_reg <= cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ==== logic/lpe_ramp_engine.v ====
`timescale 1ns/1ps
`include "lpe_defs.vh"
module lpe_ramp_engine (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // avalon-mm slave
  input  wire [8:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output wire [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  // test adc
  input  wire [7:0]  adc_result_i,
  // led current drivers
  output wire [7:0]  led_current0_o,
  output wire [7:0]  led_current1_o,
  output wire [7:0]  led_current2_o,
  output wire        engine_busy_o
);
  localparam [2:0] ST_IDLE   = 3'd0;
  localparam [2:0] ST_DECODE = 3'd1;
  localparam [2:0] ST_RAMP   = 3'd2;
  localparam [2:0] ST_DONE   = 3'd3;
  localparam [2:0] ST_ARITH  = 3'd4;

  // bus side
  reg  [31:0] rdata_reg;
  reg         ack_reg;
  wire        req     = avs_read_i | avs_write_i;
  wire        wr_fire = avs_write_i & ack_reg;
  wire [6:0]  idx     = avs_address_i[8:2];

  // host registers
  reg  [7:0]  ctrl_reg [0:2];
  reg  [7:0]  pwm_reg [0:2];
  reg  [7:0]  var_d_reg;
  reg  [7:0]  adc_reg;
  reg  [7:0]  cfg_reg;
  reg  [15:0] instr_reg;

  // engine state
  reg  [2:0]  state_reg;
  reg  [7:0]  pc_reg;
  reg  [7:0]  var_a_reg;
  reg  [7:0]  var_b_reg;
  reg  [7:0]  var_c_reg;
  reg         pre_reg;
  reg         sign_reg;
  reg  [4:0]  step_time_reg;
  reg  [4:0]  step_cnt_reg;
  reg  [7:0]  inc_left_reg;
  reg         wait_only_reg;
  reg  [1:0]  ch_reg;
  // per channel output flops live in the generate block
  wire [23:0] led_w;

  // ticks
  wire        mtick;
  wire        tick_fast;
  wire        tick_slow;
  wire        div_clr = (state_reg == ST_DECODE);
  wire        base_tick = pre_reg ? tick_slow : tick_fast;

  // master clock stays free running so engine ticks keep their phase
  lpe_divider #(.DIV(`LPE_MCLK_DIV), .WIDTH(9)) u_mclk (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .clr_i  (1'b0),
    .en_i   (1'b1),
    .tick_o (mtick)
  );

  // prescalers restart at ramp start so the first step is full length
  lpe_divider #(.DIV(`LPE_PRE_FAST_DIV), .WIDTH(4)) u_pre_fast (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .clr_i  (div_clr),
    .en_i   (mtick),
    .tick_o (tick_fast)
  );

  lpe_divider #(.DIV(`LPE_PRE_SLOW_DIV), .WIDTH(9)) u_pre_slow (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .clr_i  (div_clr),
    .en_i   (mtick),
    .tick_o (tick_slow)
  );

  // variable selector
  function [7:0] var_sel;
    input [1:0] s;
    begin
      case (s)
        2'd0:    var_sel = var_a_reg;
        2'd1:    var_sel = var_b_reg;
        2'd2:    var_sel = var_c_reg;
        default: var_sel = cfg_reg[`LPE_CFG_D_ADC_BIT] ? adc_reg : var_d_reg;
      endcase
    end
  endfunction

  // square law approximation, cheap but monotonic
  function [7:0] log_map;
    input [7:0] x;
    reg   [15:0] p;
    begin
      p = x * x;
      log_map = (x == 8'hff) ? 8'hff : p[15:8];
    end
  endfunction

  // channel 3 has no brightness reg, software must not select it
  wire [7:0] cur_pwm = pwm_reg[ch_reg];
  wire [7:0] vs_step = var_sel(instr_reg[3:2]);
  wire [7:0] vs_inc  = var_sel(instr_reg[1:0]);
  wire [7:0] vs_tgt  = var_sel(instr_reg[11:10]);
  wire [7:0] vs_one  = var_sel(instr_reg[3:2]);
  wire [7:0] vs_two  = var_sel(instr_reg[1:0]);
  wire       is_imm_ramp = ~instr_reg[15];
  wire       is_var_ramp = (instr_reg[15:6] == `LPE_OP_RAMP_VAR);
  // target 3 is host owned, arithmetic into it is dropped
  wire       is_arith    = (instr_reg[15:12] == `LPE_OP_ARITH) & (instr_reg[11:10] != 2'd3);
  wire [7:0] dec_inc     = is_imm_ramp ? instr_reg[7:0] : vs_inc;
  wire [5:0] step_next   = {1'b0, step_cnt_reg} + 6'h01;
  // a step time of 0 ends on every tick, same as 1
  wire       step_end    = (step_next >= {1'b0, step_time_reg});

  // arithmetic result, wraps modulo 256
  reg  [7:0] ar_res;
  reg        ar_valid;
  always @* begin
    ar_res   = 8'h00;
    ar_valid = 1'b1;
    case (instr_reg[9:8])
      `LPE_AR_LD:  ar_res = instr_reg[7:0];
      `LPE_AR_ADD: ar_res = vs_tgt + instr_reg[7:0];
      `LPE_AR_SUB: ar_res = vs_tgt - instr_reg[7:0];
      default: begin
        if (instr_reg[7:4] == `LPE_AR_VADD) begin
          ar_res = vs_one + vs_two;
        end else if (instr_reg[7:4] == `LPE_AR_VSUB) begin
          ar_res = vs_one - vs_two;
        end else begin
          ar_valid = 1'b0;
        end
      end
    endcase
  end

  // avalon handshake: one wait cycle, answer on the second
  assign avs_waitrequest_o = req & ~ack_reg;
  assign avs_readdata_o    = rdata_reg;
  assign engine_busy_o     = (state_reg != ST_IDLE);
  assign led_current0_o    = led_w[7:0];
  assign led_current1_o    = led_w[15:8];
  assign led_current2_o    = led_w[23:16];

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (req & ~ack_reg) begin
        rdata_reg <= 32'h0000_0000;
        if (avs_read_i) begin
          case (idx)
            `LPE_IDX_CTRL0:  rdata_reg[7:0]  <= ctrl_reg[0];
            `LPE_IDX_CTRL1:  rdata_reg[7:0]  <= ctrl_reg[1];
            `LPE_IDX_CTRL2:  rdata_reg[7:0]  <= ctrl_reg[2];
            `LPE_IDX_PWM0:   rdata_reg[7:0]  <= pwm_reg[0];
            `LPE_IDX_PWM1:   rdata_reg[7:0]  <= pwm_reg[1];
            `LPE_IDX_PWM2:   rdata_reg[7:0]  <= pwm_reg[2];
            `LPE_IDX_VAR_D:  rdata_reg[7:0]  <= var_d_reg;
            `LPE_IDX_ADC:    rdata_reg[7:0]  <= adc_reg;
            `LPE_IDX_INSTR:  rdata_reg[15:0] <= instr_reg;
            `LPE_IDX_STATUS: rdata_reg[15:0] <= {pc_reg, 5'h00, state_reg};
            `LPE_IDX_VAR_A:  rdata_reg[7:0]  <= var_a_reg;
            `LPE_IDX_CFG:    rdata_reg[7:0]  <= cfg_reg;
            default:         rdata_reg       <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // output stage, log or linear per channel
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_out
      reg [7:0] out_reg;
      assign led_w[g*8 +: 8] = out_reg;
      always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          out_reg <= `LPE_RST_8;
        end else if (ctrl_reg[g][`LPE_CTRL_LOG_EN_BIT]) begin
          out_reg <= log_map(pwm_reg[g]);
        end else begin
          out_reg <= pwm_reg[g];
        end
      end
    end
  endgenerate

  // adc result is sampled every cycle, read-only to the host
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      adc_reg <= `LPE_RST_8;
    end else begin
      adc_reg <= adc_result_i;
    end
  end

  // host registers plus the engine, one process so each reg has one driver
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg[0]   <= `LPE_RST_8;
      ctrl_reg[1]   <= `LPE_RST_8;
      ctrl_reg[2]   <= `LPE_RST_8;
      pwm_reg[0]    <= `LPE_RST_8;
      pwm_reg[1]    <= `LPE_RST_8;
      pwm_reg[2]    <= `LPE_RST_8;
      var_d_reg     <= `LPE_RST_8;
      cfg_reg       <= `LPE_RST_8;
      instr_reg     <= `LPE_RST_16;
      state_reg     <= ST_IDLE;
      pc_reg        <= `LPE_RST_8;
      var_a_reg     <= `LPE_RST_8;
      var_b_reg     <= `LPE_RST_8;
      var_c_reg     <= `LPE_RST_8;
      pre_reg       <= 1'b0;
      sign_reg      <= 1'b0;
      step_time_reg <= 5'h00;
      step_cnt_reg  <= 5'h00;
      inc_left_reg  <= `LPE_RST_8;
      wait_only_reg <= 1'b0;
      ch_reg        <= 2'h0;
    end else begin
      if (wr_fire & avs_byteenable_i[0]) begin
        case (idx)
          `LPE_IDX_CTRL0: ctrl_reg[0] <= avs_writedata_i[7:0];
          `LPE_IDX_CTRL1: ctrl_reg[1] <= avs_writedata_i[7:0];
          `LPE_IDX_CTRL2: ctrl_reg[2] <= avs_writedata_i[7:0];
          `LPE_IDX_VAR_D: var_d_reg   <= avs_writedata_i[7:0];
          `LPE_IDX_CFG:   cfg_reg     <= avs_writedata_i[7:0];
          default: ;
        endcase
        // the engine owns every channel's brightness while it runs
        if (state_reg == ST_IDLE) begin
          case (idx)
            `LPE_IDX_PWM0: pwm_reg[0] <= avs_writedata_i[7:0];
            `LPE_IDX_PWM1: pwm_reg[1] <= avs_writedata_i[7:0];
            `LPE_IDX_PWM2: pwm_reg[2] <= avs_writedata_i[7:0];
            default: ;
          endcase
        end
      end
      case (state_reg)
        ST_IDLE: begin
          // a new instruction is refused while one runs
          if (wr_fire & (idx == `LPE_IDX_INSTR) & (&avs_byteenable_i[1:0])) begin
            instr_reg <= avs_writedata_i[15:0];
            ch_reg    <= cfg_reg[`LPE_CFG_CH_LSB+1:`LPE_CFG_CH_LSB];
            state_reg <= ST_DECODE;
          end
        end
        ST_DECODE: begin
          step_cnt_reg <= 5'h00;
          if (is_imm_ramp) begin
            pre_reg       <= instr_reg[14];
            step_time_reg <= instr_reg[13:9];
            sign_reg      <= instr_reg[8];
          end else begin
            pre_reg       <= instr_reg[5];
            step_time_reg <= vs_step[4:0];
            sign_reg      <= instr_reg[4];
          end
          if (is_imm_ramp | is_var_ramp) begin
            wait_only_reg <= (dec_inc == 8'h00);
            inc_left_reg  <= (dec_inc == 8'h00) ? 8'h01 : dec_inc;
            state_reg     <= ST_RAMP;
          end else if (is_arith) begin
            state_reg <= ST_ARITH;
          end else begin
            state_reg <= ST_DONE;
          end
        end
        ST_RAMP: begin
          if (base_tick) begin
            if (step_end) begin
              step_cnt_reg <= 5'h00;
              if (~wait_only_reg) begin
                if (sign_reg) begin
                  if (cur_pwm != 8'h00) begin
                    pwm_reg[ch_reg] <= cur_pwm - 8'h01;
                  end
                end else if (cur_pwm != 8'hff) begin
                  pwm_reg[ch_reg] <= cur_pwm + 8'h01;
                end
              end
              inc_left_reg <= inc_left_reg - 8'h01;
              if (inc_left_reg == 8'h01) begin
                state_reg <= ST_DONE;
              end
            end else begin
              step_cnt_reg <= step_next[4:0];
            end
          end
        end
        ST_DONE: begin
          // wait for the tick so pc moves on the engine clock
          if (mtick) begin
            pc_reg    <= pc_reg + 8'h01;
            state_reg <= ST_IDLE;
          end
        end
        ST_ARITH: begin
          // operands are read at the tick, not at decode
          if (mtick) begin
            if (ar_valid) begin
              case (instr_reg[11:10])
                2'd0:    var_a_reg <= ar_res;
                2'd1:    var_b_reg <= ar_res;
                default: var_c_reg <= ar_res;
              endcase
            end
            pc_reg    <= pc_reg + 8'h01;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule
